// >>> common/xgc_pkg.sv
`default_nettype none

package xgc_pkg;

    // Register addresses on the management frame
    localparam logic [4:0]  REG_EXT_STATUS  = 5'h0F;
    localparam logic [4:0]  REG_GLOBAL      = 5'h10;

    // Global configuration field positions
    localparam int          GB_RESERVED_TOP = 15;
    localparam int          GB_DESKEW       = 14;
    localparam int          GB_CHAN_SYNC    = 13;
    localparam int          GB_IPG          = 12;
    localparam int          GB_CTC          = 11;
    localparam int          GB_MFP_HI       = 10;
    localparam int          GB_MFP_LO       = 9;
    localparam int          GB_LOS          = 8;
    localparam int          GB_UPPER_CFG    = 7;
    localparam int          GB_LOWER_CFG    = 6;
    localparam int          GB_PRE_HIGH     = 5;
    localparam int          GB_PRE_LOW      = 4;
    localparam int          GB_RESERVED_3   = 3;
    localparam int          GB_PRBS         = 2;
    localparam int          GB_COMMA        = 1;
    localparam int          GB_RESERVED_0   = 0;

    // Reset value, writable bits and constant read values
    localparam logic [15:0] GLOBAL_RESET    = 16'h0102;
    localparam logic [15:0] GLOBAL_WMASK    = 16'h7FF6;
    localparam logic [15:0] EXT_STATUS_VAL  = 16'h0000;
    localparam logic [15:0] UNMAPPED_VAL    = 16'h0000;

    // Management frame layout
    localparam logic [5:0]  PRE_LEN         = 6'h20;
    localparam logic [3:0]  HDR_LAST        = 4'hB;
    localparam logic [3:0]  TA_LAST         = 4'h1;
    localparam logic [3:0]  DATA_LAST       = 4'hF;
    localparam logic [1:0]  OP_WRITE        = 2'h1;
    localparam logic [1:0]  OP_READ         = 2'h2;

    // Multifunction pin source selection
    localparam logic [1:0]  MFP_IO_STD      = 2'h0;
    localparam logic [1:0]  MFP_COMMA       = 2'h1;
    localparam logic [1:0]  MFP_LOS         = 2'h2;
    localparam logic [1:0]  MFP_PRBS        = 2'h3;

    typedef enum logic [5:0] {
        S_PRE   = 6'b000001,
        S_ST    = 6'b000010,
        S_HDR   = 6'b000100,
        S_TA    = 6'b001000,
        S_WDATA = 6'b010000,
        S_RDATA = 6'b100000
    } xgc_state_t;

    typedef struct packed {
        logic       deskew_en;
        logic       chan_sync_en;
        logic       ipg_en;
        logic       ctc_global_en;
        logic [1:0] mfp_select;
        logic       los_detect_en;
        logic       upper_config;
        logic       lower_config;
        logic       preemphasis_high_bit;
        logic       preemphasis_low_bit;
        logic       prbs_en;
        logic       comma_detect_en;
    } xgc_ctrl_t;

    localparam xgc_ctrl_t CTRL_RESET = '{
        deskew_en: 1'b0, chan_sync_en: 1'b0, ipg_en: 1'b0, ctc_global_en: 1'b0,
        mfp_select: MFP_IO_STD, los_detect_en: 1'b1, upper_config: 1'b0,
        lower_config: 1'b0, preemphasis_high_bit: 1'b0, preemphasis_low_bit: 1'b0,
        prbs_en: 1'b0, comma_detect_en: 1'b0
    };

endpackage

`default_nettype wire

// >>> rtl/xgc_global_config_regs.sv
`default_nettype none

// Contract
// - Extended status register reads all zeros and ignores writes.
// - Writing global configuration overwrites all four per-channel configuration registers.
// - Global bit 15 reads zero; writes have no effect.
// - Bit 14 enables lane deskew machine; default disabled.
// - Bit 13 enables channel synchronization machine; default zero.
// - Bit 12 enables inter-packet-gap machine; default zero.
// - Bit 11 enables clock tolerance compensation; disabled after reset.
// - Bits 10:9 pick multifunction pin source: io standard, comma, loss, PRBS.
// - Bit 8 enables loss-of-signal detection on all channels; default set.
// - Bit 7 ORed with upper config pin; read-only while pin high.
// - Bit 6 ORed with lower config pin; read-only while pin high.
// - Bits 5 and 4 set transmit preemphasis; default zero, read/write.
// - Bits 3 and 0 read zero; writes ignored.
// - Bit 2 enables PRBS, ORed with PRBS pin; read-only while pin high.
// - Bit 1 enables comma alignment, default one, ANDed with sync pin.
// - Forced bits ignore writes and keep their stored value for later.
// - Per-channel compensation enable ORed with global bit 11.
module xgc_global_config_regs
    import xgc_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       reset,
    input  wire logic       mdio_in,
    output var  logic       mdio_out,
    output var  logic       mdio_oe,
    input  wire logic [4:0] phy_address,
    input  wire logic       upper_config_pin,
    input  wire logic       lower_config_pin,
    input  wire logic       prbs_enable_pin,
    input  wire logic       sync_enable_pin,
    input  wire logic       io_standard_hstl,
    input  wire logic [3:0] comma_detected,
    input  wire logic [3:0] los_status,
    input  wire logic [3:0] prbs_pass,
    input  wire logic [3:0] chan_ctc_bit,
    output var  xgc_ctrl_t  ctrl,
    output var  logic [3:0] ctc_enable,
    output var  logic [3:0] mf_pin,
    output var  logic       chan_overwrite,
    output var  logic [15:0] chan_overwrite_data
);

    xgc_state_t  state;
    xgc_state_t  next_state;
    logic [5:0]  pre_count;
    logic [5:0]  next_pre_count;
    logic [3:0]  bit_count;
    logic [3:0]  next_bit_count;
    logic [11:0] hdr;
    logic [15:0] wr_shift;
    logic [15:0] rd_shift;
    logic [15:0] global_reg;
    logic [15:0] next_global;
    logic [15:0] read_value;
    logic [15:0] global_read;
    logic [15:0] wr_data;
    logic [15:0] forced_mask;
    logic [15:0] take_mask;
    logic [1:0]  hdr_op;
    logic [4:0]  hdr_phy;
    logic [4:0]  hdr_reg;
    logic        addr_match;
    logic        read_hit;
    logic        frame_end;
    logic        global_write;
    logic        enter_rdata;
    logic        drive_ta;
    logic        pre_full;
    logic        op_is_read;
    logic        op_is_write;
    logic        sel_ext_status;
    logic        sel_global;
    logic [1:0]  mfp_sel;
    logic        eff_upper_cfg;
    logic        eff_lower_cfg;
    logic        eff_prbs;
    logic        eff_comma;
    xgc_ctrl_t   next_ctrl;

    // Header fields
    assign hdr_op      = hdr[11:10];
    assign hdr_phy     = hdr[9:5];
    assign hdr_reg     = hdr[4:0];
    assign addr_match  = (hdr_phy == phy_address);
    assign op_is_read  = (hdr_op == OP_READ);
    assign op_is_write = (hdr_op == OP_WRITE);
    assign read_hit    = addr_match && op_is_read;

    // Register and field decode
    assign sel_ext_status = (hdr_reg == REG_EXT_STATUS);
    assign sel_global     = (hdr_reg == REG_GLOBAL);
    assign mfp_sel        = global_reg[GB_MFP_HI:GB_MFP_LO];
    assign pre_full    = (pre_count == PRE_LEN);
    assign frame_end   = (bit_count == DATA_LAST);
    assign drive_ta    = (state == S_TA) && (bit_count != TA_LAST) && read_hit;
    assign enter_rdata = (state == S_TA) && (bit_count == TA_LAST) && read_hit;
    assign wr_data     = {wr_shift[14:0], mdio_in};

    assign global_write = (state == S_WDATA) && frame_end && addr_match
                          && op_is_write && sel_global;

    always_comb begin
        forced_mask               = 16'h0000;
        forced_mask[GB_UPPER_CFG] = upper_config_pin;
        forced_mask[GB_LOWER_CFG] = lower_config_pin;
        forced_mask[GB_PRBS]      = prbs_enable_pin;
        forced_mask[GB_COMMA]     = ~sync_enable_pin;
    end

    assign take_mask = GLOBAL_WMASK & ~forced_mask;

    genvar gb;
    generate
        for (gb = 0; gb < $bits(global_reg); gb++) begin : g_take
            assign next_global[gb] = take_mask[gb] ? wr_data[gb] : global_reg[gb];
        end
    endgenerate

    assign eff_upper_cfg = global_reg[GB_UPPER_CFG] | upper_config_pin;
    assign eff_lower_cfg = global_reg[GB_LOWER_CFG] | lower_config_pin;
    assign eff_prbs      = global_reg[GB_PRBS] | prbs_enable_pin;
    assign eff_comma     = global_reg[GB_COMMA] & sync_enable_pin;

    always_comb begin
        global_read               = global_reg;
        global_read[GB_UPPER_CFG] = eff_upper_cfg;
        global_read[GB_LOWER_CFG] = eff_lower_cfg;
        global_read[GB_PRBS]      = eff_prbs;
        global_read[GB_COMMA]     = eff_comma;
    end

    assign read_value = sel_ext_status ? EXT_STATUS_VAL
                      : sel_global     ? global_read
                      : UNMAPPED_VAL;

    // Frame sequencer
    always_comb begin
        next_state     = state;
        next_pre_count = pre_count;
        next_bit_count = bit_count;
        case (state)
            S_PRE: begin
                if (mdio_in) begin
                    if (!pre_full) begin
                        next_pre_count = pre_count + 6'h01;
                    end
                end else begin
                    next_pre_count = 6'h00;
                    if (pre_full) begin
                        next_state = S_ST;
                    end
                end
            end
            S_ST: begin
                next_bit_count = 4'h0;
                next_state     = mdio_in ? S_HDR : S_PRE;
            end
            S_HDR: begin
                next_bit_count = bit_count + 4'h1;
                if (bit_count == HDR_LAST) begin
                    next_bit_count = 4'h0;
                    next_state     = S_TA;
                end
            end
            S_TA: begin
                next_bit_count = bit_count + 4'h1;
                if (bit_count == TA_LAST) begin
                    next_bit_count = 4'h0;
                    next_state     = read_hit ? S_RDATA : S_WDATA;
                end
            end
            S_WDATA, S_RDATA: begin
                next_bit_count = bit_count + 4'h1;
                if (frame_end) begin
                    next_bit_count = 4'h0;
                    next_state     = S_PRE;
                end
            end
            default: begin
                next_state     = S_PRE;
                next_pre_count = 6'h00;
                next_bit_count = 4'h0;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state     <= S_PRE;
            pre_count <= 6'h00;
            bit_count <= 4'h0;
        end else begin
            state     <= next_state;
            pre_count <= next_pre_count;
            bit_count <= next_bit_count;
        end
    end

    // Header and write data capture
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            hdr      <= 12'h000;
            wr_shift <= 16'h0000;
        end else begin
            if (state == S_HDR) begin
                hdr <= {hdr[10:0], mdio_in};
            end
            if (state == S_WDATA) begin
                wr_shift <= wr_data;
            end
        end
    end

    // Read data drive: turnaround zero, then sixteen data bits
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            mdio_oe  <= 1'b0;
            mdio_out <= 1'b0;
            rd_shift <= 16'h0000;
        end else if (drive_ta) begin
            mdio_oe  <= 1'b1;
            mdio_out <= 1'b0;
        end else if (enter_rdata) begin
            mdio_out <= read_value[15];
            rd_shift <= {read_value[14:0], 1'b0};
        end else if (state == S_RDATA) begin
            mdio_oe  <= !frame_end;
            mdio_out <= frame_end ? 1'b0 : rd_shift[15];
            rd_shift <= {rd_shift[14:0], 1'b0};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            global_reg <= GLOBAL_RESET;
        end else if (global_write) begin
            global_reg <= next_global;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            chan_overwrite      <= 1'b0;
            chan_overwrite_data <= GLOBAL_RESET;
        end else begin
            chan_overwrite <= global_write;
            if (global_write) begin
                chan_overwrite_data <= next_global;
            end
        end
    end

    // Effective controls, registered below
    always_comb begin
        next_ctrl                      = CTRL_RESET;
        next_ctrl.deskew_en            = global_reg[GB_DESKEW];
        next_ctrl.chan_sync_en         = global_reg[GB_CHAN_SYNC];
        next_ctrl.ipg_en               = global_reg[GB_IPG];
        next_ctrl.ctc_global_en        = global_reg[GB_CTC];
        next_ctrl.mfp_select           = mfp_sel;
        next_ctrl.los_detect_en        = global_reg[GB_LOS];
        next_ctrl.upper_config         = eff_upper_cfg;
        next_ctrl.lower_config         = eff_lower_cfg;
        next_ctrl.preemphasis_high_bit = global_reg[GB_PRE_HIGH];
        next_ctrl.preemphasis_low_bit  = global_reg[GB_PRE_LOW];
        next_ctrl.prbs_en              = eff_prbs;
        next_ctrl.comma_detect_en      = eff_comma;
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ctrl <= CTRL_RESET;
        end else begin
            ctrl <= next_ctrl;
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < 4; ch++) begin : g_chan
            logic mf_src;

            assign mf_src = (mfp_sel == MFP_IO_STD) ? io_standard_hstl
                          : (mfp_sel == MFP_COMMA)  ? comma_detected[ch]
                          : (mfp_sel == MFP_LOS)    ? los_status[ch]
                          : prbs_pass[ch];

            always_ff @(posedge clk_sys) begin
                if (reset) begin
                    ctc_enable[ch] <= 1'b0;
                    mf_pin[ch]     <= 1'b0;
                end else begin
                    ctc_enable[ch] <= chan_ctc_bit[ch] | global_reg[GB_CTC];
                    mf_pin[ch]     <= mf_src;
                end
            end
        end
    endgenerate

endmodule

`default_nettype wire

// >>> testbench/tb_top.sv
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import xgc_pkg::*;
    logic clk_sys = 1'b0, reset = 1'b1, io_standard_hstl = 1'b0, sync_enable_pin = 1'b1;
    logic upper_config_pin = 1'b0, lower_config_pin = 1'b0, prbs_enable_pin = 1'b0;
    logic [3:0] comma_detected = '0, los_status = '0, prbs_pass = '0, chan_ctc_bit = '0;
    logic [4:0] phy_address = 5'h05;
    wire logic mdio_out, mdio_oe, sta_d, sta_en, rd_valid, chan_overwrite;
    wire logic [15:0] rd_data, chan_overwrite_data;
    wire logic [3:0] ctc_enable, mf_pin;
    wire xgc_ctrl_t ctrl;
    wire logic mdio_in = mdio_oe ? mdio_out : (sta_en ? sta_d : 1'b1);
    logic [15:0] st, w, r, rd_q[$], ow_q[$];
    int bad_count = 0, samples_checked = 0;
    xgc_global_config_regs dut (.*);
    xgc_sta sta (.*);
    always #50 clk_sys = ~clk_sys;
    task automatic check(input logic [15:0] got, exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks=%0d errors=%0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    function automatic logic [15:0] eff(input logic [15:0] s);
        logic [15:0] v;
        v = s | {8'h00, upper_config_pin, lower_config_pin, 3'b000, prbs_enable_pin, 2'b00};
        v[1] = s[1] & sync_enable_pin;
        return v;
    endfunction
    task automatic wr(input logic [4:0] ra, input logic [15:0] d);
        logic [15:0] m;
        m = GLOBAL_WMASK & ~{8'h00, upper_config_pin, lower_config_pin, 3'b000,
            prbs_enable_pin, ~sync_enable_pin, 1'b0};
        if (ra == REG_GLOBAL) begin
            st = (st & ~m) | (d & m);
            ow_q.push_back(st);
        end
        sta.xfer(OP_WRITE, phy_address, ra, d);
    endtask
    task automatic rd(input logic [4:0] ra);
        rd_q.push_back((ra == REG_GLOBAL) ? eff(st) : 16'h0000);
        sta.xfer(OP_READ, phy_address, ra, 16'h0000);
    endtask
    task automatic chk_ctrl();
        repeat (2) @(posedge clk_sys);
        r = eff(st);
        check(16'(ctrl), {3'b000, r[14:4], r[2:1]});
        check({12'h000, ctc_enable}, {12'h000, chan_ctc_bit | {4{r[11]}}});
        check({12'h000, mf_pin}, {12'h000, (r[10:9] == 2'h0) ? {4{io_standard_hstl}} :
            (r[10:9] == 2'h1) ? comma_detected : (r[10:9] == 2'h2) ? los_status : prbs_pass});
    endtask
    always @(posedge clk_sys) begin
        if (rd_valid) check(rd_data, rd_q.pop_front());
        if (chan_overwrite) check(chan_overwrite_data, ow_q.pop_front());
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        bad_count++;
        tally_and_finish();
    end
    initial begin
        void'($urandom(32'h7A43));
        st = GLOBAL_RESET;
        repeat (6) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        rd(REG_GLOBAL);
        rd(REG_EXT_STATUS);
        wr(REG_EXT_STATUS, 16'hFFFF);
        rd(REG_EXT_STATUS);
        wr(5'h1F, 16'hFFFF);
        rd(5'h1F);
        wr(REG_GLOBAL, 16'hFFFF);
        rd(REG_GLOBAL);
        chk_ctrl();
        sta.xfer(OP_WRITE, 5'h0A, REG_GLOBAL, 16'h0000);
        rd(REG_GLOBAL);
        // Foreign address read leaves the line released high
        rd_q.push_back(16'hFFFF);
        sta.xfer(OP_READ, 5'h0A, REG_GLOBAL, 16'h0000);
        for (int i = 0; i < 24; i++) begin
            @(posedge clk_sys);
            {upper_config_pin, lower_config_pin, prbs_enable_pin, sync_enable_pin} <= 4'($urandom);
            {comma_detected, los_status, prbs_pass, chan_ctc_bit} <= 16'($urandom);
            io_standard_hstl <= 1'($urandom);
            @(posedge clk_sys);
            w = 16'($urandom);
            w[10:9] = 2'(i);
            wr(REG_GLOBAL, w);
            rd(REG_GLOBAL);
            chk_ctrl();
        end
        reset <= 1'b1;
        repeat (6) @(posedge clk_sys);
        reset <= 1'b0;
        st = GLOBAL_RESET;
        @(posedge clk_sys);
        rd(REG_GLOBAL);
        chk_ctrl();
        tally_and_finish();
    end
endmodule
`default_nettype wire

// >>> testbench/xgc_global_config_regs_chk.sv
`default_nettype none
module xgc_global_config_regs_chk
    import xgc_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        reset,
    input wire logic        mdio_oe,
    input wire logic        upper_config_pin,
    input wire logic        lower_config_pin,
    input wire logic        prbs_enable_pin,
    input wire logic        sync_enable_pin,
    input wire logic        io_standard_hstl,
    input wire logic [3:0]  comma_detected,
    input wire logic [3:0]  los_status,
    input wire logic [3:0]  prbs_pass,
    input wire logic [3:0]  chan_ctc_bit,
    input wire xgc_ctrl_t   ctrl,
    input wire logic [3:0]  ctc_enable,
    input wire logic [3:0]  mf_pin,
    input wire logic        chan_overwrite,
    input wire logic [15:0] chan_overwrite_data
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    sequence s_one_pulse;
        chan_overwrite ##1 !chan_overwrite;
    endsequence
    a_ctc_or: assert property (!$past(reset) |-> ctc_enable ==
        ($past(chan_ctc_bit) | {4{ctrl.ctc_global_en}})) else $error("ctc enable mismatch");
    a_mf_select: assert property (!$past(reset) |-> mf_pin ==
        ((ctrl.mfp_select == MFP_IO_STD) ? {4{$past(io_standard_hstl)}} :
         (ctrl.mfp_select == MFP_COMMA) ? $past(comma_detected) :
         (ctrl.mfp_select == MFP_LOS) ? $past(los_status) : $past(prbs_pass)))
        else $error("multifunction pin mismatch");
    a_upper_forced: assert property (!$past(reset) && $past(upper_config_pin)
        |-> ctrl.upper_config) else $error("upper config not forced");
    a_lower_forced: assert property (!$past(reset) && $past(lower_config_pin)
        |-> ctrl.lower_config) else $error("lower config not forced");
    a_prbs_forced: assert property (!$past(reset) && $past(prbs_enable_pin)
        |-> ctrl.prbs_en) else $error("prbs enable not forced");
    a_comma_gated: assert property (!$past(reset) && !$past(sync_enable_pin)
        |-> !ctrl.comma_detect_en) else $error("comma enable not gated");
    a_reset_default: assert property (disable iff (1'b0) $past(reset)
        |-> ctrl == CTRL_RESET && !mdio_oe) else $error("reset default wrong");
    a_overwrite_resv: assert property (chan_overwrite |-> chan_overwrite_data[15] == 1'b0
        && chan_overwrite_data[3] == 1'b0 && chan_overwrite_data[0] == 1'b0)
        else $error("reserved bit in overwrite data");
    a_overwrite_pulse: assert property ($rose(chan_overwrite) |-> s_one_pulse)
        else $error("overwrite pulse too long");
endmodule
bind xgc_global_config_regs xgc_global_config_regs_chk chk (.*);
`default_nettype wire

// >>> testbench/xgc_sta.sv
`default_nettype none
module xgc_sta
    import xgc_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        mdio_in,
    output logic             sta_d,
    output logic             sta_en,
    output logic             rd_valid,
    output logic [15:0]      rd_data
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        sta_d = 1'b1;
        sta_en = 1'b0;
        rd_valid = 1'b0;
        rd_data = '0;
    end
    // One whole frame; read bits sampled at the edges the device sets them up for
    task automatic xfer(input logic [1:0] op, input logic [4:0] pa, ra, input logic [15:0] wd);
        logic [63:0] f;
        logic [15:0] acc;
        f = {32'hFFFF_FFFF, 2'b01, op, pa, ra, 2'b10, wd};
        acc = '0;
        for (int i = 0; i < 65; i++) begin
            @(posedge clk_sys);
            if (i > 48) begin
                acc = {acc[14:0], mdio_in};
            end
            if (i < 64) begin
                sta_d <= f[63-i];
                sta_en <= (i < 46) || (op == OP_WRITE);
            end
        end
        sta_en <= 1'b0;
        sta_d <= ~sta_d;
        rd_valid <= (op == OP_READ);
        rd_data <= acc;
        @(posedge clk_sys);
        rd_valid <= 1'b0;
    endtask
endmodule
`default_nettype wire
